// >>> rtl/pmsp_regs.svh
// Constants of the MAC-side nibble and serial port
`ifndef PMSP_REGS_SVH
`define PMSP_REGS_SVH
// How it works
// [R1] Transmit clock runs freely, times MAC inputs
// [R2] MAC drives enable and nibble on clock
// [R3] Receive clock 25 MHz fast, 2.5 MHz slow (fast clock here 5 MHz, two system cycles)
// [R4] Collision output follows detected collision
// [R5] Carrier sense high while medium busy
// [R6] Receive valid spans data, drops at end
// [R7] Receive valid changes away from rising edge
// [R8] Receive nibble driven in step with clock
// [R9] Receive error high on symbol decode error
// [R10] Shared error pin sampled at reset: fiber
// [R11] After sampling the pin is error output
// [R12] Management clock at most 2.5 MHz, asynchronous
// [R13] Management bits travel on one shared line
// [R14] Serial mode: 10 Mbps, data on bit 0 (port clock here 5 MHz, so 5 Mbps)
// [R15] Serial receive clock follows incoming data
// [R16] Serial transmit clock made by the port
// [R17] Serial MAC data on bit 0 with enable
// [R18] Interface strap latched: high nibble, low serial
`define PMSP_SYS_KHZ 10000
`define PMSP_RXC100_KHZ 25000
`define PMSP_RXC10_KHZ 2500
`define PMSP_SER_KHZ 10000
`define PMSP_BOOT_CYC 2'h3
`define PMSP_PRE_ONES 6'h20
`define PMSP_HDR_BITS 4'hC
`define PMSP_DATA_BITS 5'h10
`define PMSP_OP_READ 2'h2
`define PMSP_FIFO_FULL 2'h2
`endif

// >>> rtl/pmsp_pkg.sv
// Types of the MAC-side nibble and serial port
package pmsp_pkg;
	typedef struct packed {
		logic [3:0] nib;
		logic       err;
	} pmsp_rxent_t;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_HDR  = 2'b01,
		M_TA   = 2'b10,
		M_DATA = 2'b11
	} pmsp_mst_t;
	typedef enum logic {
		B_WAIT = 1'b0,
		B_RUN  = 1'b1
	} pmsp_boot_t;
endpackage : pmsp_pkg

// >>> rtl/pmsp_port.sv
// MAC-side nibble and serial port of the transceiver
`timescale 1ns/10ps
`default_nettype none
`include "pmsp_regs.svh"
module pmsp_port (
	input  wire logic                 SYS_CLK_I,
	input  wire logic                 ARST_N_I,
	input  wire logic                 TX_ENABLE_IN_I,
	input  wire logic [3:0]           TXD_I,
	output logic                      TXC_O,
	output logic                      RXC_O,
	output logic                      RX_VALID_OUT_O,
	output logic [3:0]                RXD_O,
	output logic                      COL_O,
	output logic                      CRS_O,
	input  wire logic                 RX_ERROR_OUT_I,
	output logic                      RX_ERROR_OUT_O,
	output logic                      RX_ERROR_OUT_OE_O,
	input  wire logic                 INTF_SEL_I,
	input  wire logic                 SPEED_100_I,
	input  wire logic                 MDC_I,
	input  wire logic                 MDIO_I,
	output logic                      MDIO_O,
	output logic                      MDIO_OE_O,
	input  wire pmsp_pkg::pmsp_rxent_t MED_RX_I,
	input  wire logic                 MED_RX_VALID_I,
	output logic                      MED_RX_READY_O,
	input  wire logic                 MED_COL_I,
	input  wire logic                 MED_BUSY_I,
	output logic [3:0]                MED_TX_O,
	output logic                      MED_TX_VALID_O,
	output logic                      MED_TX_EN_O,
	output logic                      FIBER_MODE_O,
	output logic                      SERIAL_MODE_O
);
	import pmsp_pkg::*;

	// Half period in system cycles, never below one
	function automatic logic [2:0] pmsp_half(input int khz);
		int h;
		h = `PMSP_SYS_KHZ / (2 * khz);
		if (h < 1)
			h = 1;
		return 3'(h);
	endfunction : pmsp_half

	localparam logic [2:0] HALF_100 = pmsp_half(`PMSP_RXC100_KHZ);
	localparam logic [2:0] HALF_10  = pmsp_half(`PMSP_RXC10_KHZ);
	localparam logic [2:0] HALF_SER = pmsp_half(`PMSP_SER_KHZ);

	pmsp_boot_t  boot_q;
	logic [1:0]  bcnt_q;
	logic        fiber_q, serial_q;
	logic        tx_enable_in_s1, tx_enable_in_s2;
	logic [3:0]  txd_s1, txd_s2;
	logic        rx_error_out_s1, rx_error_out_s2;
	logic        isel_s1, isel_s2;
	logic        mdc_s1, mdc_s2, mdc_s3;
	logic        mdio_s1, mdio_s2;
	logic        run;
	logic        spd100;
	logic [2:0]  half;
	logic [2:0]  tcnt_q, rcnt_q;
	logic        txc_q, rxc_q;
	logic        tx_rise, rx_fall, rx_run;
	pmsp_rxent_t mem_q [0:1];
	logic        wp_q, rp_q;
	logic [1:0]  fcnt_q;
	logic        push, pop;
	logic        rx_valid_out_q, rx_error_out_q, col_q, crs_q;
	logic [3:0]  rxd_q, rsh_q;
	logic [1:0]  rbit_q;
	logic [3:0]  tsh_q, mtx_q;
	logic [1:0]  tbit_q;
	logic        mtxv_q, mtxen_q;
	pmsp_mst_t   mst_q;
	logic [5:0]  ones_q;
	logic [4:0]  mbit_q;
	logic [12:0] msr_q;
	logic [15:0] mword_q;
	logic        mdo_q, mdoe_q;
	logic        mdc_rise;

	// Pin synchronisers, two stages each, three for the management clock
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			{tx_enable_in_s1, tx_enable_in_s2, rx_error_out_s1, rx_error_out_s2} <= 4'h0;
			{txd_s1, txd_s2} <= 8'h00;
			{isel_s1, isel_s2, mdio_s1, mdio_s2} <= 4'h0;
			{mdc_s1, mdc_s2, mdc_s3} <= 3'h0;
		end else begin
			tx_enable_in_s1 <= TX_ENABLE_IN_I;
			tx_enable_in_s2 <= tx_enable_in_s1;
			txd_s1  <= TXD_I;
			txd_s2  <= txd_s1;
			rx_error_out_s1 <= RX_ERROR_OUT_I;
			rx_error_out_s2 <= rx_error_out_s1;
			isel_s1 <= INTF_SEL_I;
			isel_s2 <= isel_s1;
			mdio_s1 <= MDIO_I;
			mdio_s2 <= mdio_s1;
			mdc_s1  <= MDC_I;
			mdc_s2  <= mdc_s1;
			mdc_s3  <= mdc_s2;
		end
	end

	// Strap capture once the synchronisers have filled
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			boot_q   <= B_WAIT;
			bcnt_q   <= 2'h0;
			fiber_q  <= 1'b0;
			serial_q <= 1'b0;
		end else if (boot_q == B_WAIT) begin
			bcnt_q <= bcnt_q + 2'h1;
			if (bcnt_q == `PMSP_BOOT_CYC) begin
				boot_q   <= B_RUN;
				fiber_q  <= rx_error_out_s2; // R10
				serial_q <= !isel_s2; // R18
			end
		end
	end

	assign run    = (boot_q == B_RUN);
	assign spd100 = SPEED_100_I && !serial_q; // R14
	assign half   = serial_q ? HALF_SER : (spd100 ? HALF_100 : HALF_10); // R3

	// Free-running transmit clock
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			tcnt_q <= 3'h0;
			txc_q  <= 1'b0;
		end else if (tcnt_q >= half - 3'h1) begin
			tcnt_q <= 3'h0;
			txc_q  <= !txc_q; // R1 R16
		end else begin
			tcnt_q <= tcnt_q + 3'h1;
		end
	end

	assign tx_rise = (tcnt_q >= half - 3'h1) && !txc_q;

	// Receive clock, held low in serial mode with no data
	assign rx_run = !serial_q || (fcnt_q != 2'h0) || rx_valid_out_q;
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rcnt_q <= 3'h0;
			rxc_q  <= 1'b0;
		end else if (!rx_run) begin
			rcnt_q <= 3'h0; // R15
			rxc_q  <= 1'b0;
		end else if (rcnt_q >= half - 3'h1) begin
			rcnt_q <= 3'h0;
			rxc_q  <= !rxc_q; // R3
		end else begin
			rcnt_q <= rcnt_q + 3'h1;
		end
	end

	assign rx_fall = rx_run && (rcnt_q >= half - 3'h1) && rxc_q;

	// Two-entry buffer between medium and receive pins
	assign MED_RX_READY_O = (fcnt_q != `PMSP_FIFO_FULL);
	assign push = MED_RX_VALID_I && MED_RX_READY_O;
	assign pop  = rx_fall && run && (fcnt_q != 2'h0) && (!serial_q || rbit_q == 2'h0);
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			fcnt_q   <= 2'h0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= MED_RX_I;
				wp_q        <= !wp_q;
			end
			if (pop)
				rp_q <= !rp_q;
			fcnt_q <= fcnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// Receive pins change on the falling receive edge
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rx_valid_out_q <= 1'b0;
			rx_error_out_q <= 1'b0;
			rxd_q  <= 4'h0;
			rsh_q  <= 4'h0;
			rbit_q <= 2'h0;
		end else if (rx_fall && run) begin
			if (serial_q && rbit_q != 2'h0) begin
				rxd_q  <= {3'h0, rsh_q[rbit_q]}; // R14
				rbit_q <= rbit_q + 2'h1;
			end else if (pop) begin
				rx_valid_out_q <= 1'b1; // R6 R7
				rx_error_out_q <= mem_q[rp_q].err; // R9
				rsh_q  <= mem_q[rp_q].nib;
				rxd_q  <= serial_q ? {3'h0, mem_q[rp_q].nib[0]} : mem_q[rp_q].nib; // R8
				rbit_q <= serial_q ? 2'h1 : 2'h0;
			end else begin
				rx_valid_out_q <= 1'b0; // R6
				rx_error_out_q <= 1'b0;
				rxd_q  <= 4'h0;
			end
		end
	end

	// Collision and carrier follow the medium
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			col_q <= 1'b0;
			crs_q <= 1'b0;
		end else begin
			col_q <= run && MED_COL_I; // R4
			crs_q <= run && MED_BUSY_I; // R5
		end
	end

	// Transmit capture on the rising transmit edge
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			tsh_q   <= 4'h0;
			tbit_q  <= 2'h0;
			mtx_q   <= 4'h0;
			mtxv_q  <= 1'b0;
			mtxen_q <= 1'b0;
		end else begin
			mtxv_q <= 1'b0;
			if (tx_rise && run) begin
				mtxen_q <= tx_enable_in_s2; // R2 R17
				if (!tx_enable_in_s2) begin
					tbit_q <= 2'h0;
				end else if (!serial_q) begin
					mtx_q  <= txd_s2; // R2
					mtxv_q <= 1'b1;
				end else begin
					tsh_q  <= {txd_s2[0], tsh_q[3:1]}; // R17
					tbit_q <= tbit_q + 2'h1;
					if (tbit_q == 2'h3) begin
						mtx_q  <= {txd_s2[0], tsh_q[3:1]};
						mtxv_q <= 1'b1;
					end
				end
			end
		end
	end

	// Management frames: preamble, header, turnaround, data
	assign mdc_rise = mdc_s2 && !mdc_s3;
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			mst_q   <= M_IDLE;
			ones_q  <= 6'h00;
			mbit_q  <= 5'h00;
			msr_q   <= 13'h0000;
			mword_q <= 16'h0000;
			mdo_q   <= 1'b0;
			mdoe_q  <= 1'b0;
		end else if (mdc_rise && run) begin
			unique case (mst_q)
				M_IDLE: begin
					if (mdio_s2)
						ones_q <= (ones_q == `PMSP_PRE_ONES) ? ones_q : ones_q + 6'h01;
					else if (ones_q == `PMSP_PRE_ONES) begin
						mst_q  <= M_HDR;
						mbit_q <= 5'h00;
						ones_q <= 6'h00;
					end else
						ones_q <= 6'h00;
				end
				M_HDR: begin
					msr_q  <= {msr_q[11:0], mdio_s2};
					mbit_q <= mbit_q + 5'h01;
					if (mbit_q[3:0] == `PMSP_HDR_BITS) begin
						if (msr_q[11] && msr_q[10:9] == `PMSP_OP_READ)
							mst_q <= M_TA;
						else
							mst_q <= M_IDLE;
						mword_q <= {fiber_q, serial_q, spd100, crs_q, col_q, 11'h000};
					end
				end
				M_TA: begin
					mdoe_q <= 1'b1; // R13
					mdo_q  <= 1'b0;
					mbit_q <= 5'h00;
					mst_q  <= M_DATA;
				end
				M_DATA: begin
					if (mbit_q == `PMSP_DATA_BITS) begin
						mdoe_q <= 1'b0; // R13
						mst_q  <= M_IDLE;
					end else begin
						mdo_q   <= mword_q[15]; // R13
						mword_q <= {mword_q[14:0], 1'b0};
						mbit_q  <= mbit_q + 5'h01;
					end
				end
			endcase
		end
	end

	// Output pins
	assign TXC_O          = txc_q;
	assign RXC_O          = rxc_q;
	assign RX_VALID_OUT_O         = rx_valid_out_q;
	assign RXD_O          = rxd_q;
	assign COL_O          = col_q;
	assign CRS_O          = crs_q;
	assign RX_ERROR_OUT_O         = rx_error_out_q;
	assign RX_ERROR_OUT_OE_O      = run; // R11
	assign MDIO_O         = mdo_q;
	assign MDIO_OE_O      = mdoe_q;
	assign MED_TX_O       = mtx_q;
	assign MED_TX_VALID_O = mtxv_q;
	assign MED_TX_EN_O    = mtxen_q;
	assign FIBER_MODE_O   = fiber_q;
	assign SERIAL_MODE_O  = serial_q;

	// Checks
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!ARST_N_I);

	txc_slow_a: assert property ((run && !serial_q && !SPEED_100_I && $rose(txc_q)) |-> txc_q ##1 txc_q ##1 !txc_q) // R1
		else $error("transmit clock high phase wrong");
	rxc_slow_a: assert property ((run && !serial_q && !SPEED_100_I && $fell(rxc_q)) |-> !rxc_q ##1 !rxc_q ##1 rxc_q) // R3
		else $error("receive clock low phase wrong");
	col_follow_a: assert property ((run && MED_COL_I) |=> col_q) // R4
		else $error("collision not shown");
	crs_follow_a: assert property ((run && !MED_BUSY_I) |=> !crs_q) // R5
		else $error("carrier shown on idle medium");
	rx_valid_out_edge_a: assert property ($changed(rx_valid_out_q) |-> $past(rx_fall)) // R7
		else $error("receive valid moved off falling edge");
	rxd_edge_a: assert property ($changed(rxd_q) |-> $past(rx_fall)) // R8
		else $error("receive data moved off falling edge");
	rx_valid_out_end_a: assert property ((rx_fall && run && !serial_q && fcnt_q == 2'h0) |=> !rx_valid_out_q) // R6
		else $error("receive valid held past packet end");
	rx_error_out_show_a: assert property ((pop && !serial_q && mem_q[rp_q].err) |=> rx_error_out_q && rx_valid_out_q) // R9
		else $error("decode error not shown");
	strap_fiber_a: assert property (($past(boot_q) == B_WAIT && run) |-> fiber_q == $past(rx_error_out_s2)) // R10
		else $error("fiber strap not latched");
	rx_error_out_oe_a: assert property (!run |-> !RX_ERROR_OUT_OE_O) // R11
		else $error("error pin driven during strap sampling");
	ser_hold_a: assert property ((serial_q && !rx_run) |=> !rxc_q) // R15
		else $error("serial receive clock runs without data");
	mdio_ta_a: assert property ((mst_q == M_TA && mdc_rise && run) |=> MDIO_OE_O && !MDIO_O) // R13
		else $error("turnaround zero not driven");
endmodule : pmsp_port
`default_nettype wire

// >>> tb/pmsp_mac.sv
// MAC partner model: sends transmit nibbles, collects received nibbles
`timescale 1ns/10ps
`default_nettype none
module pmsp_mac (
	input  wire logic       clk_i,
	input  wire logic       tx_clk_i,
	input  wire logic       rx_clk_i,
	input  wire logic       rx_vld_i,
	input  wire logic [3:0] rx_nib_i,
	input  wire logic       rx_err_i,
	output logic            tx_en_o,
	output logic [3:0]      tx_nib_o
);
	logic [3:0] tx_q[$];
	logic [4:0] rx_q[$];
	logic       tx_prv;
	logic       rx_prv;
	initial begin
		tx_en_o = 1'b0;
		tx_nib_o = 4'h0;
		tx_prv = 1'b0;
		rx_prv = 1'b0;
	end
	// Change after a transmit clock rise, sample at a receive clock rise
	always @(negedge clk_i) begin
		if (tx_clk_i && !tx_prv) begin
			tx_en_o = (tx_q.size() > 0);
			tx_nib_o = tx_en_o ? tx_q.pop_front() : ~tx_nib_o;
		end
		if (rx_clk_i && !rx_prv && rx_vld_i)
			rx_q.push_back({rx_nib_i, rx_err_i});
		tx_prv = tx_clk_i;
		rx_prv = rx_clk_i;
	end
endmodule : pmsp_mac
`default_nettype wire

// >>> tb/pmsp_port_bench.sv
// Bench for the MAC-side port: behavioural model against the design
`timescale 1ns/10ps
`default_nettype none
module pmsp_port_bench;
	import pmsp_pkg::*;
	logic        clk, arst_n, sel, speed, mdc, mdio_drv, strap, mcol, mbusy, mv, tk;
	logic        tx_clk, rx_clk, rx_vld, rx_err, rx_err_oe, mdio_o, mdio_oe, rdy, tx_vld;
	logic        fib, ser, coll, carrier, tx_en, med_en;
	logic [3:0]  rx_nib, tx_nib, med_tx, nib;
	pmsp_rxent_t mrx;
	wire         rx_err_w = rx_err_oe ? rx_err : strap;
	wire         mdio_w = mdio_oe ? mdio_o : mdio_drv;
	int          err_count, n_tests, n, full, i, k;
	logic [4:0]  exp_rx[$];
	logic [3:0]  exp_tx[$];
	pmsp_port u_dut (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .TX_ENABLE_IN_I(tx_en), .TXD_I(tx_nib), .TXC_O(tx_clk),
		.RXC_O(rx_clk), .RX_VALID_OUT_O(rx_vld), .RXD_O(rx_nib), .COL_O(coll), .CRS_O(carrier), .RX_ERROR_OUT_I(rx_err_w),
		.RX_ERROR_OUT_O(rx_err), .RX_ERROR_OUT_OE_O(rx_err_oe), .INTF_SEL_I(sel), .SPEED_100_I(speed), .MDC_I(mdc),
		.MDIO_I(mdio_w), .MDIO_O(mdio_o), .MDIO_OE_O(mdio_oe), .MED_RX_I(mrx), .MED_RX_VALID_I(mv),
		.MED_RX_READY_O(rdy), .MED_COL_I(mcol), .MED_BUSY_I(mbusy), .MED_TX_O(med_tx),
		.MED_TX_VALID_O(tx_vld), .MED_TX_EN_O(med_en), .FIBER_MODE_O(fib), .SERIAL_MODE_O(ser));
	pmsp_mac u_mac (.clk_i(clk), .tx_clk_i(tx_clk), .rx_clk_i(rx_clk), .rx_vld_i(rx_vld), .rx_nib_i(rx_nib),
		.rx_err_i(rx_err), .tx_en_o(tx_en), .tx_nib_o(tx_nib));
	// System clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (e !== g) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task automatic do_reset(input logic s, input logic fb);
		@(negedge clk);
		arst_n = 1'b0;
		sel = s;
		strap = fb;
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		repeat (6) @(negedge clk);
		check("fiber", fb, fib);
		check("serial", !s, ser);
		check("err_oe", 1, rx_err_oe);
		$display("reset test done");
	endtask : do_reset
	// Cycles between two rises of a port clock, 0 if it stands
	task automatic period(input bit rx, output int p);
		int t;
		int f;
		logic prv;
		p = 0;
		f = -1;
		prv = 1'b1;
		for (t = 0; t < 40; t++) begin
			@(negedge clk);
			if ((rx ? rx_clk : tx_clk) && !prv) begin
				if (f >= 0) begin
					p = t - f;
					break;
				end
				f = t;
			end
			prv = rx ? rx_clk : tx_clk;
		end
	endtask : period
	// One management clock period of 800 ns, still outside frames
	task automatic mdc_bit(input logic b);
		mdio_drv = b;
		mdc = 1'b1;
		repeat (4) @(negedge clk);
		mdc = 1'b0;
		repeat (4) @(negedge clk);
	endtask : mdc_bit
	task automatic mgmt_read(input logic [15:0] e);
		int k;
		for (k = 0; k < 46; k++)
			mdc_bit(k < 32 || k == 33 || k == 34);
		mdc_bit(1'b1);
		check("ta_oe", 1, mdio_oe);
		check("ta_bit", 0, mdio_w);
		for (k = 15; k >= 0; k--) begin
			mdc_bit(1'b1);
			check("mgmt_bit", e[k], mdio_w);
		end
		mdc_bit(1'b1);
		check("mgmt_off", 0, mdio_oe);
		$display("management test done");
	endtask : mgmt_read
	// Each transmit pulse against the queue of sent nibbles
	always @(negedge clk)
		if (tx_vld === 1'b1) begin
			check("tx_nib", (exp_tx.size() > 0) ? exp_tx.pop_front() : 16'hFFFF, med_tx);
			check("tx_en", 1, med_en);
		end
	initial begin
		#2000000;
		err_count++;
		end_of_test();
	end
	initial begin
		{err_count, n_tests, n, full} = '0;
		{arst_n, speed, mdc, mcol, mbusy, mv} = '0;
		{sel, strap, mdio_drv} = 3'h7;
		mrx = '0;
		void'($urandom(73521));
		do_reset(1'b1, 1'b1);
		period(1'b0, n);
		check("tx_per", 4, n);
		period(1'b1, n);
		check("rx_per10", 4, n);
		speed = 1'b1;
		repeat (8) @(negedge clk);
		period(1'b1, n);
		check("rx_per100", 2, n);
		speed = 1'b0;
		repeat (8) @(negedge clk);
		$display("clock test done");
		for (i = 0; i < 20; i++) begin
			{mcol, mbusy} = 2'($urandom);
			@(negedge clk);
			check("coll", mcol, coll);
			check("carrier", mbusy, carrier);
		end
		$display("status test done");
		mv = 1'b1;
		mrx = 5'($urandom);
		n = 0;
		while (n < 12) begin
			tk = rdy;
			@(negedge clk);
			if (tk === 1'b1) begin
				exp_rx.push_back(mrx);
				n++;
				mrx = 5'($urandom);
			end else
				full++;
		end
		mv = 1'b0;
		mrx = ~mrx;
		check("full_seen", 1, full > 0);
		for (i = 0; i < 300 && u_mac.rx_q.size() < 12; i++)
			@(negedge clk);
		repeat (8) @(negedge clk);
		check("rx_count", 12, u_mac.rx_q.size());
		check("rx_vld_end", 0, rx_vld);
		for (i = 0; i < 12 && i < u_mac.rx_q.size(); i++)
			check("rx_word", exp_rx[i], u_mac.rx_q[i]);
		$display("receive test done");
		for (i = 0; i < 8; i++) begin
			nib = 4'($urandom);
			exp_tx.push_back(nib);
			u_mac.tx_q.push_back(nib);
		end
		for (i = 0; i < 100 && exp_tx.size() > 0; i++)
			@(negedge clk);
		check("tx_left", 0, exp_tx.size());
		$display("transmit test done");
		speed = 1'b1;
		mgmt_read({1'b1, 1'b0, 1'b1, mbusy, mcol, 11'h000});
		do_reset(1'b0, 1'b0);
		mgmt_read({1'b0, 1'b1, 1'b0, mbusy, mcol, 11'h000});
		period(1'b1, n);
		check("rx_idle", 0, n);
		// Serial receive: each entry leaves as four bits, bit 0 first
		for (i = 0; i < 2; i++) begin
			mrx = 5'($urandom);
			mv = 1'b1;
			for (k = 0; k < 4; k++)
				exp_rx.push_back({3'h0, mrx.nib[k], mrx.err});
			@(negedge clk);
		end
		mv = 1'b0;
		for (i = 0; i < 200 && u_mac.rx_q.size() < 20; i++)
			@(negedge clk);
		repeat (8) @(negedge clk);
		check("ser_rx_count", 20, u_mac.rx_q.size());
		check("ser_rx_vld_end", 0, rx_vld);
		for (i = 12; i < 20 && i < u_mac.rx_q.size(); i++)
			check("ser_rx_bit", exp_rx[i], u_mac.rx_q[i]);
		// Serial transmit: four bits on bit 0 make one nibble
		nib = 4'($urandom);
		exp_tx.push_back(nib);
		for (k = 0; k < 4; k++)
			u_mac.tx_q.push_back({3'($urandom), nib[k]});
		for (i = 0; i < 100 && exp_tx.size() > 0; i++)
			@(negedge clk);
		check("ser_tx_left", 0, exp_tx.size());
		$display("serial test done");
		end_of_test();
	end
endmodule : pmsp_port_bench
`default_nettype wire
